// ---- include/sci_link_if.sv ----
// command, address and data pins between the controller and the memory
// assumes both ends share sys_clk; dq is resolved here from the two enables
`timescale 1ns/1ns
`default_nettype none
interface sci_link_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic bank_select_high;
	logic bank_select_low;
	logic [12:0] row_address_lines;
	logic [15:0] dq_ctl_out;
	logic dq_ctl_oe;
	logic [15:0] dq_mem_out;
	logic dq_mem_oe;
	logic [15:0] dq;
	assign dq = (dq_ctl_oe ? dq_ctl_out : 16'h0000) | (dq_mem_oe ? dq_mem_out : 16'h0000);
	modport mem (
		input cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low,
		input row_address_lines, dq,
		output dq_mem_out, dq_mem_oe
	);
	modport ctl (
		output cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low,
		output row_address_lines, dq_ctl_out, dq_ctl_oe,
		input dq
	);
endinterface : sci_link_if
`default_nettype wire

// ---- include/sci_pkg.sv ----
// constants, types and command codes shared by the memory end and the controller end
// assumes one 50 MHz clock shared by both ends; the link carries one 16-bit chip slice
// Summary of operation
// R1 - all inputs sampled on rising clock edge
// R2 - four banks, 8192 rows, 1024 columns, 16-bit
// R3 - open row with activate before read/write
// R4 - activate takes bank bits and thirteen row lines
// R5 - read/write takes start column from ten lines
// R6 - burst 1,2,4,8 or page; terminate ends early
// R7 - auto precharge closes row after burst
// R8 - new column accepted every clock cycle
// R9 - banks precharge independently of each other
// R10 - controller waits 100 us before real commands
// R11 - controller drives nop throughout power-up wait
// R12 - then precharge all banks to reach idle
// R13 - two auto refreshes before mode load
// R14 - mode register undefined until loaded
// R15 - mode fields: length, type, latency, op, write
// R16 - mode loaded only when idle, then wait
// R17 - read latency two or three clocks
// R18 - controller refreshes periodically after init
package sci_pkg;
	localparam int CLK_MHZ = 50;
	localparam int BANK_W = 2;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int NUM_BANKS = 4;
	localparam int ROWS = 8192;
	localparam int COLS = 1024;
	localparam int MEM_WORDS = NUM_BANKS * ROWS * COLS;
	localparam int IDX_W = BANK_W + ROW_W + COL_W;
	localparam int AP_BIT = 10;
	localparam int LEN_W = 11;
	// mode register field positions
	localparam int BL_LSB = 0;
	localparam int BL_W = 3;
	localparam int BT_BIT = 3;
	localparam int LAT_LSB = 4;
	localparam int LAT_W = 3;
	localparam int OPM_LSB = 7;
	localparam int WBM_BIT = 9;
	localparam logic [BL_W-1:0] BL_FULL = 3'h7;
	localparam logic [LAT_W-1:0] LAT_2 = 3'h2;
	localparam logic [LAT_W-1:0] LAT_3 = 3'h3;
	localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
	// timing, each time in its own unit and its cycle count at CLK_MHZ
	localparam int POWERUP_US = 100;
	localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
	localparam int T_RP_NS = 20;
	localparam int T_RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RCD_NS = 20;
	localparam int T_RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RC_NS = 70;
	localparam int T_RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
	localparam int T_MRD_CYC = 2;
	localparam int REF_INT_NS = 7812;
	localparam int REF_INT_CYC = REF_INT_NS * CLK_MHZ / 1000;
	localparam int ACC_GAP_CYC = T_RC_CYC + T_RP_CYC + 3;
	localparam int CNT_W = 16;
	localparam int PRE_W = 3;
	localparam int TRACK_W = 4;
	localparam int FIFO_DEPTH = 8;
	// command codes are {ras_n, cas_n, we_n} with cs_n low
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sci_cmd_t;
	typedef enum logic [3:0] {
		ST_POWERUP = 4'h0,
		ST_PRE_ALL = 4'h1,
		ST_REF1 = 4'h2,
		ST_REF2 = 4'h3,
		ST_LMR = 4'h4,
		ST_IDLE = 4'h5,
		ST_ACT = 4'h6,
		ST_RW = 4'h7,
		ST_REFRESH = 4'h8,
		ST_WAIT = 4'h9
	} sci_ctl_state_t;
endpackage : sci_pkg

// ---- sim/sci_asserts.sv ----
// link checker: power-up order, command spacing and read timing seen on the pins
// assumes one clock and an active-high reset shared by both ends
`timescale 1ns/1ns
`default_nettype none
module sci_asserts
	import sci_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [12:0] row_address_lines,
	input wire logic dq_ctl_oe,
	input wire logic dq_mem_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] cmd;
	logic [1:0] ref_q;
	logic [1:0] ref_d;
	logic seen_q;
	logic seen_d;
	logic [15:0] wait_q;
	logic [15:0] wait_d;
	assign cmd = cs_n ? 3'h7 : {ras_n, cas_n, we_n};
	// count refreshes and the quiet edges before the first real command
	always_comb begin
		ref_d = ref_q + 2'((cmd == CMD_REF) && (ref_q != 2'h3));
		seen_d = seen_q | (cmd != CMD_NOP);
		wait_d = seen_q ? wait_q : wait_q + 16'h0001;
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_q <= 2'h0;
			seen_q <= 1'b0;
			wait_q <= 16'h0000;
		end else begin
			ref_q <= ref_d;
			seen_q <= seen_d;
			wait_q <= wait_d;
		end
	end
	property p_powerup_wait;
		(cmd != CMD_NOP && !seen_q) |-> wait_q >= POWERUP_CYCLES - 1;
	endproperty
	property p_first_pre;
		(cmd != CMD_NOP && !seen_q) |-> cmd == CMD_PRE && row_address_lines[AP_BIT];
	endproperty
	property p_two_ref;
		cmd == CMD_LMR |-> ref_q >= 2'h2;
	endproperty
	property p_mrd_gap;
		cmd == CMD_LMR |=> cmd == CMD_NOP;
	endproperty
	property p_act_rd;
		cmd == CMD_RD |-> $past(cmd, 2) == CMD_ACT;
	endproperty
	property p_auto_pre;
		cmd inside {CMD_RD, CMD_WR} |-> row_address_lines[AP_BIT];
	endproperty
	property p_wr_data;
		cmd == CMD_WR |-> dq_ctl_oe && !dq_mem_oe;
	endproperty
	property p_rd_lat;
		cmd == CMD_RD |-> ##[2:3] dq_mem_oe;
	endproperty
	property p_one_beat;
		$rose(dq_mem_oe) |=> !dq_mem_oe;
	endproperty
	a_powerup_wait: assert property (p_powerup_wait) else $error("command before wait");
	a_first_pre: assert property (p_first_pre) else $error("first command not pre");
	a_two_ref: assert property (p_two_ref) else $error("mode load early");
	a_mrd_gap: assert property (p_mrd_gap) else $error("no gap after load");
	a_act_rd: assert property (p_act_rd) else $error("read without open row");
	a_auto_pre: assert property (p_auto_pre) else $error("auto precharge missing");
	a_wr_data: assert property (p_wr_data) else $error("write data not driven");
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
	a_one_beat: assert property (p_one_beat) else $error("burst too long");
	c_load: cover property (cmd == CMD_LMR);
	c_write: cover property (cmd == CMD_WR);
	c_read3: cover property (cmd == CMD_RD ##3 dq_mem_oe);
endmodule : sci_asserts
`default_nettype wire

// ---- sim/sdram_command_and_init_tb.sv ----
// bench: both ends joined on the link, writes through the fifo, reads checked
// assumes 50 MHz clock and a shortened power-up count
`timescale 1ns/1ns
`default_nettype none
module sdram_command_and_init_tb;
	import sci_pkg::*;
	localparam int PU = 20;
	logic sys_clk = 0, sys_rst = 1, clk_en = 1, lat3 = 0, req_valid = 0, req_write = 0;
	logic wr_valid = 0, req_ready, wr_ready, rd_valid, init_done, mode_loaded, banks_idle;
	logic [1:0] req_bank = 0, refresh_seen;
	logic [12:0] req_row = 0;
	logic [9:0] req_col = 0;
	logic [15:0] wr_data = 0, rd_data;
	logic [31:0] lfsr_q = 32'h0001_0A26;
	logic [15:0] ref_mem [logic [24:0]];
	int fail_count = 0, total_checks = 0, k2 = 0;
	sci_link_if link ();
	sci_mem sci_mem_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .link(link),
		.mode_loaded(mode_loaded), .banks_idle(banks_idle), .refresh_seen(refresh_seen));
	sci_ctl #(.POWERUP_CYCLES(PU)) sci_ctl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .link(link), .cas_latency_three(lat3), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
		.req_col(req_col), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done));
	sci_asserts #(.POWERUP_CYCLES(PU)) sci_asserts_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.row_address_lines(link.row_address_lines), .dq_ctl_oe(link.dq_ctl_oe),
		.dq_mem_oe(link.dq_mem_oe));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] rnd();
		lfsr_q = lfsr_q[0] ? (lfsr_q >> 1) ^ 32'h8020_0003 : lfsr_q >> 1;
		return lfsr_q[15:0];
	endfunction : rnd
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	// selects the design output that a wait loop watches
	function automatic logic pick(input int s);
		case (s)
			0: return wr_ready;
			1: return req_ready;
			2: return rd_valid;
			default: return init_done;
		endcase
	endfunction : pick
	// every task is entered and left 2 ns after a rising edge
	task automatic step_until(input int s, output int k);
		k = 0;
		while (pick(s) !== 1'b1 && k < 2000) begin
			@(posedge sys_clk);
			#2;
			k++;
		end
		if (k >= 2000) begin
			fail_count++;
			$display("CHECK FAILED wait %0d expected 1 seen timeout", s);
			print_verdict();
		end
	endtask : step_until
	task automatic push(input logic [15:0] d);
		int k;
		wr_valid = 1;
		wr_data = d;
		step_until(0, k);
		@(posedge sys_clk);
		#2;
		wr_valid = 0;
		@(posedge sys_clk);
		#2;
	endtask : push
	task automatic req(input logic w, input logic [24:0] a);
		int k;
		{req_write, req_bank, req_row, req_col} = {w, a};
		req_valid = 1;
		step_until(1, k);
		@(posedge sys_clk);
		#2;
		req_valid = 0;
		@(posedge sys_clk);
		#2;
	endtask : req
	task automatic rd(input logic [24:0] a, output int k);
		req(0, a);
		step_until(2, k);
		check("rd_data", ref_mem[a], rd_data);
	endtask : rd
	task automatic init(input logic l3);
		int k;
		sys_rst = 1;
		lat3 = l3;
		repeat (12) @(posedge sys_clk);
		#2;
		check("mode_loaded in reset", 0, mode_loaded);
		sys_rst = 0;
		step_until(3, k);
		check("refresh_seen", 2, refresh_seen);
		check("mode_loaded", 1, mode_loaded);
		check("banks_idle", 1, banks_idle);
	endtask : init
	initial begin
		logic [24:0] a [8];
		logic [15:0] d;
		logic [15:0] r;
		int k;
		#2;
		init(0);
		a[0] = {2'h3, 13'h1FFF, 10'h3FF};
		a[1] = 25'h000_0000;
		a[2] = {2'h1, 13'h1FFF, 10'h000};
		// fill the fifo while no write request drains it
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			if (i > 2) begin
				r = rnd();
				a[i] = {r[8:0], rnd()};
			end
			ref_mem[a[i]] = d;
			push(d);
		end
		check("wr_ready full", 0, wr_ready);
		for (int i = 0; i < 8; i++) begin
			req(1, a[i]);
		end
		check("wr_ready empty", 1, wr_ready);
		for (int i = 0; i < 8; i++) begin
			rd(a[i], k);
			if (i == 0) begin
				k2 = k;
			end
		end
		repeat (400) @(posedge sys_clk);
		#2;
		check("refresh_seen periodic", 3, refresh_seen);
		init(1);
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			a[0] = {r[8:0], rnd()};
			d = rnd();
			ref_mem[a[0]] = d;
			push(d);
			req(1, a[0]);
			rd(a[0], k);
			check("latency three", 16'(k2 + 1), 16'(k));
		end
		print_verdict();
	end
	initial begin
		#(20 * 40000);
		fail_count++;
		print_verdict();
	end
endmodule : sdram_command_and_init_tb
`default_nettype wire

// ---- src/sci_ctl.sv ----
// controller end: power-up sequence, single-word accesses with auto precharge, refresh
// assumes sci_mem on the link; write data is buffered ahead of its request
`timescale 1ns/1ns
`default_nettype none
module sci_ctl
	import sci_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	sci_link_if.ctl link,
	input wire logic cas_latency_three,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [BANK_W-1:0] req_bank,
	input wire logic [ROW_W-1:0] req_row,
	input wire logic [COL_W-1:0] req_col,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [DATA_W-1:0] wr_data,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic init_done
);
	sci_ctl_state_t state_q, state_d, after_q, after_d;
	logic [CNT_W-1:0] wait_q, wait_d, pwr_q, pwr_d, refc_q, refc_d;
	logic cs_n_q, cs_n_d;
	logic [2:0] cmd_q, cmd_d;
	logic [ADDR_W-1:0] addr_q, addr_d, mode_word;
	logic [BANK_W-1:0] ba_q, ba_d, bank_l_q, bank_l_d;
	logic [ROW_W-1:0] row_l_q, row_l_d;
	logic [COL_W-1:0] col_l_q, col_l_d;
	logic wr_l_q, wr_l_d;
	logic [DATA_W-1:0] dq_q, dq_d, rd_data_q, rd_data_d;
	logic dq_oe_q, dq_oe_d, ready_q, ready_d, init_q, init_d;
	logic rd_valid_q, rd_valid_d, lat3_q, lat3_d, take, cap;
	logic [TRACK_W-1:0] track_q, track_d;
	logic fifo_valid, fifo_pop;
	logic [DATA_W-1:0] fifo_data;

	sci_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	always_comb begin
		mode_word = '0;
		mode_word[LAT_LSB +: LAT_W] = cas_latency_three ? LAT_3 : LAT_2; // [R15]
		take = req_valid && ready_q;
		state_d = state_q;
		after_d = after_q;
		wait_d = wait_q;
		pwr_d = pwr_q;
		refc_d = (init_q && refc_q != '1) ? refc_q + CNT_W'(1) : refc_q;
		cs_n_d = 1'b0;
		cmd_d = CMD_NOP; // [R11]
		addr_d = addr_q;
		ba_d = ba_q;
		bank_l_d = bank_l_q;
		row_l_d = row_l_q;
		col_l_d = col_l_q;
		wr_l_d = wr_l_q;
		dq_d = dq_q;
		dq_oe_d = 1'b0;
		fifo_pop = 1'b0;
		init_d = init_q;
		lat3_d = lat3_q;
		track_d = {track_q[TRACK_W-2:0], 1'b0};
		unique case (state_q)
			ST_POWERUP: begin
				if (pwr_q == CNT_W'(POWERUP_CYCLES - 1)) begin
					state_d = ST_PRE_ALL; // [R10]
				end else begin
					pwr_d = pwr_q + CNT_W'(1);
				end
			end
			ST_PRE_ALL: begin
				cmd_d = CMD_PRE;
				addr_d = '0;
				addr_d[AP_BIT] = 1'b1; // [R12]
				wait_d = CNT_W'(T_RP_CYC);
				after_d = ST_REF1;
				state_d = ST_WAIT;
			end
			ST_REF1, ST_REF2: begin
				cmd_d = CMD_REF; // [R13]
				wait_d = CNT_W'(T_RC_CYC);
				after_d = (state_q == ST_REF1) ? ST_REF2 : ST_LMR;
				state_d = ST_WAIT;
			end
			ST_LMR: begin
				cmd_d = CMD_LMR; // [R14]
				lat3_d = cas_latency_three;
				addr_d = mode_word;
				ba_d = '0;
				wait_d = CNT_W'(T_MRD_CYC); // [R16]
				after_d = ST_IDLE;
				state_d = ST_WAIT;
			end
			ST_IDLE: begin
				init_d = 1'b1;
				if (refc_q >= CNT_W'(REF_INT_CYC)) begin
					state_d = ST_REFRESH; // [R18]
				end else if (take) begin
					bank_l_d = req_bank;
					row_l_d = req_row;
					col_l_d = req_col;
					wr_l_d = req_write;
					state_d = ST_ACT;
				end
			end
			ST_ACT: begin
				cmd_d = CMD_ACT; // [R3]
				ba_d = bank_l_q;
				addr_d = row_l_q; // [R4]
				wait_d = CNT_W'(T_RCD_CYC);
				after_d = ST_RW;
				state_d = ST_WAIT;
			end
			ST_RW: begin
				if (!wr_l_q || fifo_valid) begin
					cmd_d = wr_l_q ? CMD_WR : CMD_RD;
					addr_d = '0;
					addr_d[COL_W-1:0] = col_l_q; // [R5]
					addr_d[AP_BIT] = 1'b1;
					if (wr_l_q) begin
						dq_d = fifo_data;
						dq_oe_d = 1'b1;
						fifo_pop = 1'b1;
					end else begin
						track_d[0] = 1'b1;
					end
					wait_d = CNT_W'(ACC_GAP_CYC);
					after_d = ST_IDLE;
					state_d = ST_WAIT;
				end
			end
			ST_REFRESH: begin
				cmd_d = CMD_REF; // [R18]
				refc_d = '0;
				wait_d = CNT_W'(T_RC_CYC);
				after_d = ST_IDLE;
				state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (wait_q <= CNT_W'(1)) begin
					state_d = after_q;
				end else begin
					wait_d = wait_q - CNT_W'(1);
				end
			end
			default: state_d = ST_IDLE;
		endcase
		ready_d = state_d == ST_IDLE && refc_d < CNT_W'(REF_INT_CYC);
		cap = lat3_q ? track_q[3] : track_q[2]; // [R17]
		rd_valid_d = cap;
		rd_data_d = cap ? link.dq : rd_data_q;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_POWERUP;
			after_q <= ST_IDLE;
			wait_q <= '0;
			pwr_q <= '0;
			refc_q <= '0;
			cs_n_q <= 1'b1;
			cmd_q <= CMD_NOP;
			addr_q <= '0;
			ba_q <= '0;
			bank_l_q <= '0;
			row_l_q <= '0;
			col_l_q <= '0;
			wr_l_q <= 1'b0;
			dq_q <= '0;
			dq_oe_q <= 1'b0;
			ready_q <= 1'b0;
			init_q <= 1'b0;
			lat3_q <= 1'b0;
			track_q <= '0;
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			after_q <= after_d;
			wait_q <= wait_d;
			pwr_q <= pwr_d;
			refc_q <= refc_d;
			cs_n_q <= cs_n_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			ba_q <= ba_d;
			bank_l_q <= bank_l_d;
			row_l_q <= row_l_d;
			col_l_q <= col_l_d;
			wr_l_q <= wr_l_d;
			dq_q <= dq_d;
			dq_oe_q <= dq_oe_d;
			ready_q <= ready_d;
			init_q <= init_d;
			lat3_q <= lat3_d;
			track_q <= track_d;
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
		end
	end

	assign link.cs_n = cs_n_q;
	assign {link.ras_n, link.cas_n, link.we_n} = cmd_q;
	assign {link.bank_select_high, link.bank_select_low} = ba_q;
	assign link.row_address_lines = addr_q;
	assign link.dq_ctl_out = dq_q;
	assign link.dq_ctl_oe = dq_oe_q;
	assign req_ready = ready_q;
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign init_done = init_q;
endmodule : sci_ctl
`default_nettype wire

// ---- src/sci_fifo.sv ----
// first-in first-out buffer with valid/ready on both sides
// assumes DEPTH is a power of two; ready and valid come from flops
`timescale 1ns/1ns
`default_nettype none
module sci_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PTR_W:0] count_q, count_d;
	logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
	logic push, pop;

	always_comb begin
		push = in_valid & in_ready_q;
		pop = out_ready & out_valid_q;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		count_d = count_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
		in_ready_d = count_d != (PTR_W + 1)'(DEPTH);
		out_valid_d = count_d != '0;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			in_ready_q <= 1'b1;
			out_valid_q <= 1'b0;
		end else if (clk_en) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			count_q <= count_d;
			in_ready_q <= in_ready_d;
			out_valid_q <= out_valid_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en && push) begin
			mem[wr_q] <= in_data;
		end
	end

	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = mem[rd_q];
endmodule : sci_fifo
`default_nettype wire

// ---- src/sci_mem.sv ----
// memory end: command decode, bank rows, burst engine, read pipeline and storage
// assumes the controller keeps the power-up, refresh and mode-load order
`timescale 1ns/1ns
`default_nettype none
module sci_mem
	import sci_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	sci_link_if.mem link,
	output logic mode_loaded,
	output logic banks_idle,
	output logic [1:0] refresh_seen
);
	// storage for one chip, every word of every bank [R2]
	bit [DATA_W-1:0] mem [MEM_WORDS];

	logic sel, is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_lmr;
	logic [BANK_W-1:0] bank_sel;
	logic [COL_W-1:0] column_address_lines;
	logic ap_line;
	logic all_idle;

	logic [ADDR_W-1:0] mode_q, mode_d;
	logic mode_loaded_q, mode_loaded_d;
	logic idle_q;
	logic [1:0] refresh_q, refresh_d;

	logic [NUM_BANKS-1:0] open_v;
	logic [NUM_BANKS-1:0] busy_v;
	logic [ROW_W-1:0] row_v [NUM_BANKS];

	logic burst_on_q, burst_on_d;
	logic burst_wr_q, burst_wr_d;
	logic burst_ap_q, burst_ap_d;
	logic [BANK_W-1:0] burst_bank_q, burst_bank_d;
	logic [COL_W-1:0] burst_start_q, burst_start_d;
	logic [LEN_W-1:0] burst_cnt_q, burst_cnt_d;
	logic [LEN_W-1:0] burst_len_q, burst_len_d;

	logic beat_go, beat_wr;
	logic [BANK_W-1:0] beat_bank;
	logic [COL_W-1:0] beat_col;
	logic [IDX_W-1:0] beat_idx;
	logic ap_close;
	logic [BANK_W-1:0] ap_bank;

	logic [LEN_W-1:0] mode_len;
	logic [LEN_W-1:0] start_len;
	logic interleave;
	logic lat3;

	logic pipe0_v_q, pipe0_v_d, pipe1_v_q;
	logic [DATA_W-1:0] pipe0_q, pipe0_d, pipe1_q;
	logic dq_oe_q, dq_oe_d;
	logic [DATA_W-1:0] dq_out_q, dq_out_d;

	// position of beat cnt inside the block that holds the start column
	function automatic logic [COL_W-1:0] burst_col(
		input logic [COL_W-1:0] start,
		input logic [LEN_W-1:0] cnt,
		input logic [LEN_W-1:0] len,
		input logic inter
	);
		logic [COL_W-1:0] mask;
		logic [COL_W-1:0] off;
		mask = COL_W'(len - LEN_W'(1));
		off = inter ? (start ^ cnt[COL_W-1:0]) : (start + cnt[COL_W-1:0]);
		burst_col = (start & ~mask) | (off & mask);
	endfunction : burst_col

	// command decode straight from the pins sampled at this edge [R1]
	always_comb begin
		sel = ~link.cs_n;
		is_act = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_ACT;
		is_rd = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_RD;
		is_wr = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_WR;
		is_bst = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_BST;
		is_pre = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_PRE;
		is_ref = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_REF;
		is_lmr = sel && {link.ras_n, link.cas_n, link.we_n} == CMD_LMR;
		bank_sel = {link.bank_select_high, link.bank_select_low}; // [R4]
		column_address_lines = link.row_address_lines[COL_W-1:0]; // [R5]
		ap_line = link.row_address_lines[AP_BIT];
		all_idle = ~|open_v && ~|busy_v;
	end

	// mode register fields [R15]
	always_comb begin
		unique case (mode_q[BL_LSB +: BL_W])
			3'h0: mode_len = 11'h001;
			3'h1: mode_len = 11'h002;
			3'h2: mode_len = 11'h004;
			3'h3: mode_len = 11'h008;
			BL_FULL: mode_len = 11'h400;
			default: mode_len = 11'h001;
		endcase
		interleave = mode_q[BT_BIT] && mode_q[BL_LSB +: BL_W] != BL_FULL;
		lat3 = mode_q[LAT_LSB +: LAT_W] == LAT_3; // [R17]
		start_len = (is_wr && mode_q[WBM_BIT]) ? 11'h001 : mode_len; // [R6]
	end

	// mode load only with every bank idle; refreshes counted for status [R14]
	always_comb begin
		mode_d = mode_q;
		mode_loaded_d = mode_loaded_q;
		refresh_d = refresh_q;
		if (is_lmr && all_idle) begin
			mode_d = link.row_address_lines;
			mode_loaded_d = 1'b1;
		end
		if (is_ref && all_idle && refresh_q != 2'h3) begin
			refresh_d = refresh_q + 2'h1;
		end
	end

	// one row latch and one precharge timer per bank [R9]
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		logic open_q, open_d;
		logic [ROW_W-1:0] row_q, row_d;
		logic [PRE_W-1:0] pre_q, pre_d;
		always_comb begin
			open_d = open_q;
			row_d = row_q;
			pre_d = (pre_q != '0) ? pre_q - PRE_W'(1) : pre_q;
			if (is_pre && (ap_line || bank_sel == BANK_W'(b))) begin
				open_d = 1'b0; // [R12]
				pre_d = PRE_W'(T_RP_CYC);
			end else if (ap_close && ap_bank == BANK_W'(b)) begin
				open_d = 1'b0; // [R7]
				pre_d = PRE_W'(T_RP_CYC);
			end else if (is_act && bank_sel == BANK_W'(b) && !open_q && pre_q == '0) begin
				open_d = 1'b1; // [R3]
				row_d = link.row_address_lines; // [R4]
			end
		end
		always_ff @(posedge sys_clk or posedge sys_rst) begin
			if (sys_rst) begin
				open_q <= 1'b0;
				row_q <= '0;
				pre_q <= '0;
			end else if (clk_en) begin
				open_q <= open_d;
				row_q <= row_d;
				pre_q <= pre_d;
			end
		end
		assign open_v[b] = open_q;
		assign busy_v[b] = pre_q != '0;
		assign row_v[b] = row_q;
	end

	// burst engine: a new read/write restarts it on any cycle [R8]
	always_comb begin
		burst_on_d = burst_on_q;
		burst_wr_d = burst_wr_q;
		burst_ap_d = burst_ap_q;
		burst_bank_d = burst_bank_q;
		burst_start_d = burst_start_q;
		burst_cnt_d = burst_cnt_q;
		burst_len_d = burst_len_q;
		beat_go = 1'b0;
		beat_wr = burst_wr_q;
		beat_bank = burst_bank_q;
		beat_col = burst_col(burst_start_q, burst_cnt_q, burst_len_q, interleave);
		ap_close = 1'b0;
		ap_bank = burst_bank_q;
		if ((is_rd || is_wr) && mode_loaded_q && open_v[bank_sel]) begin
			beat_go = 1'b1; // [R3]
			beat_wr = is_wr;
			beat_bank = bank_sel;
			beat_col = column_address_lines; // [R5]
			burst_wr_d = is_wr;
			burst_ap_d = ap_line;
			burst_bank_d = bank_sel;
			burst_start_d = column_address_lines;
			burst_len_d = start_len;
			burst_cnt_d = 11'h001;
			burst_on_d = start_len != 11'h001;
			if (start_len == 11'h001 && ap_line) begin
				ap_close = 1'b1; // [R7]
				ap_bank = bank_sel;
			end
		end else if (is_bst) begin
			burst_on_d = 1'b0; // [R6]
		end else if (burst_on_q) begin
			beat_go = 1'b1;
			burst_cnt_d = burst_cnt_q + 11'h001;
			if (burst_cnt_d == burst_len_q) begin
				burst_on_d = 1'b0;
				ap_close = burst_ap_q; // [R7]
			end
		end
		beat_idx = {beat_bank, row_v[beat_bank], beat_col};
	end

	// read data leaves latency minus one edges after the command edge [R17]
	always_comb begin
		pipe0_v_d = beat_go && !beat_wr;
		pipe0_d = mem[beat_idx];
		dq_oe_d = lat3 ? pipe1_v_q : pipe0_v_q;
		dq_out_d = lat3 ? pipe1_q : pipe0_q;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= MODE_RESET;
			mode_loaded_q <= 1'b0;
			refresh_q <= 2'h0;
			idle_q <= 1'b1;
			burst_on_q <= 1'b0;
			burst_wr_q <= 1'b0;
			burst_ap_q <= 1'b0;
			burst_bank_q <= '0;
			burst_start_q <= '0;
			burst_cnt_q <= '0;
			burst_len_q <= 11'h001;
			pipe0_v_q <= 1'b0;
			pipe0_q <= '0;
			pipe1_v_q <= 1'b0;
			pipe1_q <= '0;
			dq_oe_q <= 1'b0;
			dq_out_q <= '0;
		end else if (clk_en) begin
			mode_q <= mode_d;
			mode_loaded_q <= mode_loaded_d;
			refresh_q <= refresh_d;
			idle_q <= all_idle;
			burst_on_q <= burst_on_d;
			burst_wr_q <= burst_wr_d;
			burst_ap_q <= burst_ap_d;
			burst_bank_q <= burst_bank_d;
			burst_start_q <= burst_start_d;
			burst_cnt_q <= burst_cnt_d;
			burst_len_q <= burst_len_d;
			pipe0_v_q <= pipe0_v_d;
			pipe0_q <= pipe0_d;
			pipe1_v_q <= pipe0_v_q;
			pipe1_q <= pipe0_q;
			dq_oe_q <= dq_oe_d;
			dq_out_q <= dq_out_d;
		end
	end

	// write beats store the data word sampled with the command or beat [R1]
	always_ff @(posedge sys_clk) begin
		if (clk_en && beat_go && beat_wr) begin
			mem[beat_idx] <= link.dq;
		end
	end

	assign link.dq_mem_out = dq_out_q;
	assign link.dq_mem_oe = dq_oe_q;
	assign mode_loaded = mode_loaded_q;
	assign banks_idle = idle_q;
	assign refresh_seen = refresh_q;
endmodule : sci_mem
`default_nettype wire
